// ==== rtl/deic_event_irq.sv ====
// Purpose: event-interrupt resources, clear port and fault status
// Assumes: strobes are one-cycle pulses on pclk; fault pin is async
// Notes:   apb slave instanced here, one wait state per access
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "deic_params.svh"
module deic_event_irq (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [`DEIC_ADDR_W-1:0]  paddr,
    input  wire logic [31:0]              pwdata,
    output logic                          pready,
    output logic [31:0]                   prdata,
    output logic                          pslverr,
    input  wire logic                     send_event_instruction,
    input  wire logic [4:0]               send_event_num,
    input  wire logic                     wait_for_event_instruction,
    input  wire logic [4:0]               wait_for_event_num,
    input  wire logic                     manager_fault_flag,
    output logic [`DEIC_NUM_RES-1:0]      irq,
    output logic [`DEIC_NUM_RES-1:0]      event_pending,
    output logic                          intr
);
    deic_pkg::deic_core_regs_t c_reg;
    deic_pkg::deic_core_regs_t c_next;

    logic [31:0] rd_value;
    logic        rd_hit;
    logic        acc_go;
    logic        wr_go;
    logic        rd_go;
    logic [`DEIC_NUM_RES-1:0] sev_hit;
    logic [`DEIC_NUM_RES-1:0] wfe_hit;
    logic [`DEIC_NUM_RES-1:0] clr_hit;
    logic [`DEIC_NUM_RES-1:0] raw_next;
    logic [`DEIC_NUM_RES-1:0] irq_next;
    logic [`DEIC_NUM_EVT_SRC-1:0] evt;

    deic_apb_slave u_apb (
        .pclk     (pclk),
        .presetn  (presetn),
        .psel     (psel),
        .penable  (penable),
        .pwrite   (pwrite),
        .paddr    (paddr),
        .rd_value (rd_value),
        .rd_hit   (rd_hit),
        .pready   (pready),
        .prdata   (prdata),
        .pslverr  (pslverr),
        .acc_go   (acc_go)
    );

    assign wr_go = acc_go && pwrite;
    assign rd_go = acc_go && !pwrite;

    // per-resource set and clear terms; set wins over a same-cycle clear
    genvar gi;
    generate
        for (gi = 0; gi < `DEIC_NUM_RES; gi = gi + 1) begin : g_res
            assign sev_hit[gi] = send_event_instruction
                              && (send_event_num == 5'(gi));
            assign wfe_hit[gi] = wait_for_event_instruction
                              && (wait_for_event_num == 5'(gi))
                              && !c_reg.select[gi];
            assign clr_hit[gi] = wr_go && (paddr == `DEIC_OFF_CLR)
                              && pwdata[gi]
                              && c_reg.select[gi];
            // raw bit covers both uses of the resource
            assign raw_next[gi] = sev_hit[gi]
                               || (c_reg.raw[gi]
                                   && !wfe_hit[gi]
                                   && !clr_hit[gi]);
            assign irq_next[gi] = (sev_hit[gi] && c_reg.select[gi])
                               || (c_reg.irq[gi] && !clr_hit[gi]
                                   && c_reg.select[gi]);
        end
    endgenerate

    // event sources for the local summary interrupt
    always_comb begin
        evt = '0;
        evt[`DEIC_EVT_SEV_IRQ]   = |(sev_hit & c_reg.select);
        evt[`DEIC_EVT_SEV_EVT]   = |(sev_hit & ~c_reg.select);
        evt[`DEIC_EVT_WFE_CLR]   = |wfe_hit;
        evt[`DEIC_EVT_MGR_FAULT] = c_reg.fault_sync[1] && !c_reg.fault_seen;
    end

    // register read mux
    always_comb begin
        rd_hit   = 1'b1;
        rd_value = 32'h0;
        case (paddr)
            `DEIC_OFF_RAW:       rd_value = c_reg.raw;
            // irq only ever set for interrupt-selected resources
            `DEIC_OFF_MIS:       rd_value = c_reg.irq
                                          & c_reg.select;
            `DEIC_OFF_CLR:       rd_value = 32'h0;
            `DEIC_OFF_MGR_FAULT: rd_value = {31'h0,
                                             c_reg.mgr_fault};
            `DEIC_OFF_SELECT:    rd_value = c_reg.select;
            `DEIC_OFF_IRQ_STAT:  rd_value = {28'h0, c_reg.stat};
            `DEIC_OFF_IRQ_MASK:  rd_value = {28'h0, c_reg.mask};
            default:             rd_hit   = 1'b0;
        endcase
    end

    always_comb begin
        c_next     = c_reg;
        c_next.raw = raw_next;
        c_next.irq = irq_next;
        // fault pin arrives from another state machine's timing
        c_next.fault_sync = {c_reg.fault_sync[0], manager_fault_flag};
        c_next.mgr_fault  = c_reg.fault_sync[1];
        c_next.fault_seen = c_reg.fault_sync[1];
        if (wr_go && paddr == `DEIC_OFF_SELECT) begin
            c_next.select = pwdata;
        end
        if (wr_go && paddr == `DEIC_OFF_IRQ_MASK) begin
            c_next.mask = pwdata[`DEIC_NUM_EVT_SRC-1:0];
        end
        // pending kept in a flop so the pin never glitches
        c_next.pending = c_next.raw & ~c_next.select;
        // read clears status; a fresh event in that cycle still lands
        if (rd_go && paddr == `DEIC_OFF_IRQ_STAT) begin
            c_next.stat = evt;
        end else begin
            c_next.stat = c_reg.stat | evt;
        end
        c_next.irq_any = |(c_next.stat & c_next.mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            c_reg <= '{raw: `DEIC_RES_RST, irq: `DEIC_RES_RST,
                       pending: `DEIC_RES_RST,
                       select: `DEIC_SELECT_RST,
                       stat: `DEIC_STAT_RST, mask: `DEIC_MASK_RST,
                       irq_any: 1'b0, mgr_fault: 1'b0,
                       fault_sync: 2'b00, fault_seen: 1'b0};
        end else begin
            c_reg <= c_next;
        end
    end

    assign irq           = c_reg.irq;
    assign event_pending = c_reg.pending;
    assign intr          = c_reg.irq_any;
endmodule : deic_event_irq

// ==== rtl/deic_params.svh ====
// Purpose: constants for the event/interrupt status and clear block
// Assumes: 32-bit apb data, byte addresses
// Notes:   offsets are local choices
`ifndef DEIC_PARAMS_SVH
`define DEIC_PARAMS_SVH

`define DEIC_NUM_RES        32
`define DEIC_ADDR_W         12
`define DEIC_OFF_RAW        12'h020
`define DEIC_OFF_MIS        12'h028
`define DEIC_OFF_CLR        12'h02c
`define DEIC_OFF_MGR_FAULT  12'h030
`define DEIC_OFF_SELECT     12'h040
`define DEIC_OFF_IRQ_STAT   12'h050
`define DEIC_OFF_IRQ_MASK   12'h054
`define DEIC_SELECT_RST     32'h0000_0000
`define DEIC_RES_RST        32'h0000_0000
`define DEIC_STAT_RST       4'h0
`define DEIC_MASK_RST       4'h0
`define DEIC_NUM_EVT_SRC    4
`define DEIC_EVT_SEV_IRQ    0
`define DEIC_EVT_SEV_EVT    1
`define DEIC_EVT_WFE_CLR    2
`define DEIC_EVT_MGR_FAULT  3

`endif

// ==== rtl/deic_pkg.sv ====
// Purpose: shared types for the event/interrupt block
// Assumes: deic_params.svh included first by users
// Notes:   types only
package deic_pkg;
    typedef enum logic [1:0] {
        DEIC_IDLE   = 2'b00,
        DEIC_ACCESS = 2'b01
    } deic_apb_state_t;

    typedef struct packed {
        deic_apb_state_t state;
        logic [31:0]     prdata;
        logic            pready;
        logic            pslverr;
    } deic_apb_regs_t;

    typedef struct packed {
        logic [31:0] raw;
        logic [31:0] irq;
        logic [31:0] select;
        logic [31:0] pending;
        logic [3:0]  stat;
        logic [3:0]  mask;
        logic        irq_any;
        logic        mgr_fault;
        logic [1:0]  fault_sync;
        logic        fault_seen;
    } deic_core_regs_t;
endpackage : deic_pkg

// ==== rtl/deic_apb_slave.sv ====
// Purpose: apb slave front end, one wait state per access
// Assumes: single pclk domain
// Notes:   unmapped addresses answer with pslverr
`timescale 1ns/1ps
`include "deic_params.svh"
module deic_apb_slave (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [`DEIC_ADDR_W-1:0] paddr,
    input  wire logic [31:0]             rd_value,
    input  wire logic                    rd_hit,
    output logic                         pready,
    output logic [31:0]                  prdata,
    output logic                         pslverr,
    output logic                         acc_go
);
    deic_pkg::deic_apb_regs_t r_reg;
    deic_pkg::deic_apb_regs_t r_next;

    always_comb begin
        r_next         = r_reg;
        r_next.pready  = 1'b0;
        acc_go         = 1'b0;
        case (r_reg.state)
            deic_pkg::DEIC_IDLE: begin
                if (psel && !penable) begin
                    r_next.state = deic_pkg::DEIC_ACCESS;
                end
            end
            deic_pkg::DEIC_ACCESS: begin
                // answer in the second access cycle so read data is settled
                if (psel && penable && !r_reg.pready) begin
                    acc_go         = 1'b1;
                    r_next.pready  = 1'b1;
                    r_next.pslverr = !rd_hit;
                    r_next.prdata  = (!pwrite && rd_hit) ? rd_value : 32'h0;
                    r_next.state   = deic_pkg::DEIC_IDLE;
                end else if (!psel) begin
                    r_next.state = deic_pkg::DEIC_IDLE;
                end
            end
            default: begin
                r_next.state = deic_pkg::DEIC_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg <= '{state: deic_pkg::DEIC_IDLE, prdata: 32'h0,
                       pready: 1'b0, pslverr: 1'b0};
        end else begin
            r_reg <= r_next;
        end
    end

    assign pready  = r_reg.pready;
    assign prdata  = r_reg.prdata;
    assign pslverr = r_reg.pslverr;
endmodule : deic_apb_slave

// ==== verif/deic_event_irq_props.sv ====
// Purpose: port-level checks for deic_event_irq
// Assumes: one wait state apb, strobes one cycle each
// Notes:   fault read check needs the pin steady for five cycles
`timescale 1ns/1ps
`include "deic_params.svh"
module deic_event_irq_props (
    input wire logic                    pclk,
    input wire logic                    presetn,
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic                    pwrite,
    input wire logic [`DEIC_ADDR_W-1:0] paddr,
    input wire logic [31:0]             pwdata,
    input wire logic                    pready,
    input wire logic [31:0]             prdata,
    input wire logic                    send_event_instruction,
    input wire logic [4:0]              send_event_num,
    input wire logic                    wait_for_event_instruction,
    input wire logic [4:0]              wait_for_event_num,
    input wire logic                    manager_fault_flag,
    input wire logic [31:0]             irq,
    input wire logic [31:0]             event_pending
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // access cycle before the single wait state ends; writes land here
    wire acc = psel & penable & !pready;
    wire sev = send_event_instruction;
    sequence s_clr_wr;
        acc && pwrite && paddr == `DEIC_OFF_CLR && !sev;
    endsequence
    sequence s_fault_rd;
        acc && !pwrite && paddr == `DEIC_OFF_MGR_FAULT
            && manager_fault_flag == $past(manager_fault_flag, 5);
    endsequence
    chk_sev_sets_one: assert property (sev |=>
        irq[$past(send_event_num)] ^ event_pending[$past(send_event_num)])
        else $error("send-event set no resource");
    chk_irq_rise_cause: assert property (
        (irq & ~$past(irq)) != 32'h0 |-> $past(sev))
        else $error("irq rose without send-event");
    // a select write may expose a raw bit as pending
    chk_pend_rise_cause: assert property (
        (event_pending & ~$past(event_pending)) != 32'h0
        |-> $past(sev) || $past(acc && pwrite))
        else $error("pending rose without cause");
    chk_wfe_clears: assert property (
        wait_for_event_instruction && !sev
        |=> !event_pending[$past(wait_for_event_num)])
        else $error("wait-for-event left event pending");
    chk_clr_lowers: assert property (s_clr_wr |=>
        (irq & $past(pwdata)) == 32'h0) else $error("clear left irq high");
    chk_clr_zero_keep: assert property (s_clr_wr |=>
        (irq & ~$past(pwdata)) == ($past(irq) & ~$past(pwdata)))
        else $error("clear changed a zero-written bit");
    chk_irq_fall_cause: assert property (
        (~irq & $past(irq)) != 32'h0 |-> $past(acc && pwrite))
        else $error("irq fell without write");
    // read data is latched in the access cycle and shows one edge later
    chk_fault_bit: assert property (s_fault_rd |=>
        prdata[0] == $past(manager_fault_flag))
        else $error("fault bit wrong");
endmodule : deic_event_irq_props
bind deic_event_irq deic_event_irq_props u_props (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .send_event_instruction, .send_event_num, .wait_for_event_instruction,
    .wait_for_event_num, .manager_fault_flag, .irq, .event_pending);

// ==== verif/deic_partner.sv ====
// Purpose: instruction-thread model issuing send and wait strobes
// Assumes: cmd 1 send-event, 2 wait-for-event, 0 idle
// Notes:   numbers scramble between strobes so stale values never help
`timescale 1ns/1ps
module deic_partner (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [1:0] cmd,
    input  wire logic [4:0] num,
    output logic            sev,
    output logic [4:0]      sev_num,
    output logic            wfe,
    output logic [4:0]      wfe_num
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {sev, wfe, sev_num, wfe_num} <= 12'h0;
        end else begin
            sev     <= cmd == 2'h1;
            wfe     <= cmd == 2'h2;
            sev_num <= (cmd == 2'h1) ? num : ~sev_num;
            wfe_num <= (cmd == 2'h2) ? num : ~wfe_num;
        end
    end
endmodule : deic_partner

// ==== verif/deic_event_irq_tb.sv ====
// Purpose: self-checking bench for deic_event_irq
// Assumes: one wait state apb, strobes from the partner model
// Notes:   fault pin held steady around its reads
`timescale 1ns/1ps
`include "deic_params.svh"
module deic_event_irq_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [`DEIC_ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rdata, irq, event_pending;
    logic pready, pslverr, rerr, intr, flag = 0, sev, wfe;
    logic [1:0] cmd = 2'h0;
    logic [4:0] num = 5'h0, sev_num, wfe_num;
    int bad_count = 0, total_checks = 0, cyc = 0;
    always #10 pclk = ~pclk;
    deic_partner PM (.pclk, .presetn, .cmd, .num, .sev, .sev_num, .wfe,
        .wfe_num);
    deic_event_irq DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pready, .prdata, .pslverr, .send_event_instruction(sev),
        .send_event_num(sev_num), .wait_for_event_instruction(wfe),
        .wait_for_event_num(wfe_num), .manager_fault_flag(flag), .irq,
        .event_pending, .intr);
    task chk(input string nm, input logic [31:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask : chk
    // request stands until pready is seen high at a rising edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        {psel, penable} <= 2'h0;
    endtask : apb
    task pulse(input logic [1:0] k, input logic [4:0] n);
        @(posedge pclk);
        {cmd, num} <= {k, n};
        @(posedge pclk);
        cmd <= 2'h0;
        repeat (2) @(negedge pclk);
    endtask : pulse
    task t_irq;
        apb(1, `DEIC_OFF_SELECT, 32'h8000_0001);
        pulse(1, 31);
        chk("irq", irq, 32'h8000_0000);
        chk("pend", event_pending, 32'h0);
        apb(0, `DEIC_OFF_RAW, 0);
        chk("raw", rdata, 32'h8000_0000);
        apb(0, `DEIC_OFF_MIS, 0);
        chk("mis", rdata, 32'h8000_0000);
        apb(0, `DEIC_OFF_MIS, 0);
        chk("mis2", rdata, 32'h8000_0000);
        apb(1, `DEIC_OFF_CLR, 32'h7fff_ffff);
        repeat (2) @(negedge pclk);
        chk("irq kept", irq, 32'h8000_0000);
        apb(1, `DEIC_OFF_IRQ_MASK, 32'h1);
        repeat (2) @(negedge pclk);
        chk("intr on", intr, 1'b1);
        apb(1, `DEIC_OFF_IRQ_MASK, 32'h0);
        repeat (2) @(negedge pclk);
        chk("intr masked", intr, 1'b0);
        apb(1, `DEIC_OFF_IRQ_MASK, 32'h1);
        apb(0, `DEIC_OFF_IRQ_STAT, 0);
        chk("stat", rdata, 32'h1);
        repeat (2) @(negedge pclk);
        chk("intr off", intr, 1'b0);
        apb(1, `DEIC_OFF_CLR, 32'h8000_0000);
        repeat (2) @(negedge pclk);
        chk("irq clr", irq, 32'h0);
        apb(0, `DEIC_OFF_RAW, 0);
        chk("raw clr", rdata, 32'h0);
        $display("test irq done");
    endtask : t_irq
    task t_event;
        pulse(1, 5);
        chk("pend", event_pending, 32'h20);
        chk("no irq", irq, 32'h0);
        apb(0, `DEIC_OFF_MIS, 0);
        chk("mis evt", rdata, 32'h0);
        apb(1, `DEIC_OFF_CLR, 32'h20);
        repeat (2) @(negedge pclk);
        chk("pend kept", event_pending, 32'h20);
        apb(0, `DEIC_OFF_RAW, 0);
        chk("raw pend", rdata, 32'h20);
        pulse(2, 5);
        chk("pend clr", event_pending, 32'h0);
        apb(0, `DEIC_OFF_RAW, 0);
        chk("raw evt", rdata, 32'h0);
        apb(0, `DEIC_OFF_IRQ_STAT, 0);
        chk("stat evt", rdata, 32'h6);
        $display("test event done");
    endtask : t_event
    task t_misc;
        apb(0, 12'h0fc, 0);
        chk("unmapped", rerr, 1'b1);
        apb(0, `DEIC_OFF_MGR_FAULT, 0);
        chk("flt0", rdata[0], 1'b0);
        chk("mapped", rerr, 1'b0);
        flag <= 1'b1;
        repeat (6) @(posedge pclk);
        apb(0, `DEIC_OFF_MGR_FAULT, 0);
        chk("flt1", rdata[0], 1'b1);
        apb(0, `DEIC_OFF_IRQ_STAT, 0);
        chk("stat flt", rdata, 32'h8);
        // reset again with an irq and an event both standing
        pulse(1, 31);
        pulse(1, 3);
        chk("irq pre", irq, 32'h8000_0000);
        chk("pend pre", event_pending, 32'h8);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk("irq rst2", irq, 32'h0);
        chk("pend rst2", event_pending, 32'h0);
        apb(0, `DEIC_OFF_RAW, 0);
        chk("raw rst2", rdata, 32'h0);
        $display("test misc done");
    endtask : t_misc
    task end_of_test;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            end_of_test();
        end
    end
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk("irq rst", irq, 32'h0);
        apb(0, `DEIC_OFF_RAW, 0);
        chk("raw rst", rdata, 32'h0);
        t_irq();
        t_event();
        t_misc();
        end_of_test();
    end
endmodule : deic_event_irq_tb
